// File: rtl/poe_cfg_pkg.sv
package poe_cfg_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] OFS_STRAP = 8'h11;
  localparam logic [7:0] OFS_MODE = 8'h12;
  localparam logic [7:0] OFS_UNPLUG = 8'h13;
  localparam logic [7:0] OFS_DISCOVERY = 8'h14;
  localparam logic [7:0] OFS_BACKOFF = 8'h15;
  localparam logic [7:0] OFS_TIMERS = 8'h16;

  // Port count and field positions
  localparam int NUM_PORTS = 4;
  localparam int STRAP_ADDR_LSB = 2;
  localparam int STRAP_MIDSPAN_BIT = 1;
  localparam int STRAP_AUTO_BIT = 0;
  localparam int AC_LSB = 4;
  localparam int DC_LSB = 0;
  localparam int CLS_LSB = 4;
  localparam int DET_LSB = 0;
  localparam int RESTART_OFF_SELECT_LSB = 6;
  localparam int TSTART_LSB = 4;
  localparam int TFAULT_LSB = 2;
  localparam int UNPLUG_TIMEOUT_SELECT_LSB = 0;

  // Fixed reset values; the strap-dependent ones are built from the latch
  localparam logic [7:0] TIMERS_RESET = 8'h00;
  localparam logic [3:0] UPPER_NIBBLE_RESET = 4'h0;

  // Timing: clock period and the millisecond tick derived from it
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  localparam logic [11:0] TSTART_NOM_MS = 12'h03c;
  localparam logic [11:0] TFAULT_NOM_MS = 12'h03c;
  localparam logic [11:0] UNPLUG_TIMEOUT_SELECT_NOM_MS = 12'h15e;
  localparam logic [11:0] BACKOFF_MS = 12'h898;

  // Operating mode codes per port
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_MANUAL = 2'b01,
    MODE_SEMI = 2'b10,
    MODE_AUTO = 2'b11
  } port_mode_t;

  // Latched strap inputs, ordered as they read back
  typedef struct packed {
    logic [3:0] addr;
    logic midspan;
    logic autonomous;
  } strap_t;

  // Timer selects, ordered as in the timing register
  typedef struct packed {
    logic [1:0] restart_off_select;
    logic [1:0] tstart;
    logic [1:0] tfault;
    logic [1:0] unplug_timeout_select;
  } timer_sel_t;

  // Startup and fault time scaling: x1, x1/2, x2, x4
  function automatic logic [11:0] scale_limit(input logic [11:0] nom, input logic [1:0] sel);
    logic [11:0] r;
    unique case (sel)
      2'b00: r = nom;
      2'b01: r = nom >> 1;
      2'b10: r = nom << 1;
      default: r = nom << 2;
    endcase
    return r;
  endfunction

  // Disconnect time scaling: x1, x1/4, x1/2, x2
  function automatic logic [11:0] scale_disc(input logic [11:0] nom, input logic [1:0] sel);
    logic [11:0] r;
    unique case (sel)
      2'b00: r = nom;
      2'b01: r = nom >> 2;
      2'b10: r = nom >> 1;
      default: r = nom << 1;
    endcase
    return r;
  endfunction

  // Fault counter discharge divider: 16, 32, 64 ticks per step, or instant
  function automatic logic [6:0] restart_div(input logic [1:0] sel);
    logic [6:0] r;
    unique case (sel)
      2'b00: r = 7'h10;
      2'b01: r = 7'h20;
      2'b10: r = 7'h40;
      default: r = 7'h00;
    endcase
    return r;
  endfunction

endpackage

// File: rtl/poe_strap_capture.sv
`timescale 1ns/1ns
`default_nettype none
module poe_strap_capture
  import poe_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] pins,
  output strap_t strap
);

  // Three-stage synchroniser; runs unreset so it settles while reset is held
  logic [5:0] s1_q, s2_q, s3_q;
  strap_t latch_q, latch_d;

  // Latch follows agreed pin levels only while reset is asserted
  always_comb begin
    latch_d = latch_q;
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          latch_d[i] = s3_q[i];
        end
      end
    end
  end

  // No async reset here: the latch must capture during reset, not be cleared by it
  always_ff @(posedge clk) begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
    latch_q <= latch_d;
  end

  assign strap = latch_q;

endmodule
`default_nettype wire

// File: rtl/poe_port_timer.sv
`timescale 1ns/1ns
`default_nettype none
module poe_port_timer
  import poe_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ms_tick,
  input wire timer_sel_t sel,
  input wire logic restart_en,
  input wire logic soft_reset,
  input wire logic powered,
  input wire logic in_startup,
  input wire logic power_good,
  input wire logic in_limit,
  input wire logic mps_seen,
  input wire logic monitor_en,
  input wire logic detect_fail,
  input wire logic backoff_en,
  output logic oc_shutdown,
  output logic unplug_shutdown,
  output logic restart_hold,
  output logic backoff_hold,
  output logic monitor_active
);

  // Fault counter in ms, discharge prescaler and fault flag
  logic [TMR_W-1:0] oc_q, oc_d;
  logic [6:0] div_q, div_d;
  logic faulted_q, faulted_d;
  // Unplug and backoff counters in ms
  logic [TMR_W-1:0] unplug_q, unplug_d, boff_q, boff_d;
  logic oc_pulse_q, oc_pulse_d, unplug_pulse_q, unplug_pulse_d, mon_q, mon_d;
  logic [TMR_W-1:0] limit;
  logic [6:0] rdiv;

  // Startup limit while starting up, fault limit otherwise
  assign limit = in_startup ? scale_limit(TSTART_NOM_MS, sel.tstart) : scale_limit(TFAULT_NOM_MS, sel.tfault);
  assign rdiv = restart_div(sel.restart_off_select);

  // Next-state for all per-port timers
  always_comb begin
    oc_d = oc_q;
    div_d = div_q;
    faulted_d = faulted_q;
    unplug_d = unplug_q;
    boff_d = boff_q;
    oc_pulse_d = 1'b0;
    unplug_pulse_d = 1'b0;
    mon_d = powered && !in_startup && power_good && monitor_en;
    if (faulted_q) begin
      // Discharge sets how long the port stays off
      if (rdiv == 7'h00) begin
        oc_d = '0;
        faulted_d = 1'b0;
      end else if (ms_tick) begin
        if (div_q + 7'h01 >= rdiv) begin
          div_d = '0;
          oc_d = oc_q - 12'h001;
          faulted_d = (oc_q != 12'h001);
        end else begin
          div_d = div_q + 7'h01;
        end
      end
    end else if (powered && in_limit) begin
      if (ms_tick) begin
        oc_d = oc_q + 12'h001;
        if (oc_q + 12'h001 >= limit) begin
          oc_d = limit;
          faulted_d = (limit != 12'h000);
          oc_pulse_d = 1'b1;
          div_d = '0;
        end
      end
    end else begin
      // Limit condition gone before timeout: forget the partial count
      oc_d = '0;
    end
    // Missing maintain-power signature counts toward unplug
    if (!mon_q || mps_seen || soft_reset) begin
      unplug_d = '0;
    end else if (ms_tick) begin
      unplug_d = unplug_q + 12'h001;
      if (unplug_q >= scale_disc(UNPLUG_TIMEOUT_SELECT_NOM_MS, sel.unplug_timeout_select)) begin
        unplug_pulse_d = 1'b1;
        unplug_d = '0;
      end
    end
    // Cadence backoff after a failed detection
    if (soft_reset) begin
      boff_d = '0;
    end else if (detect_fail && backoff_en) begin
      boff_d = BACKOFF_MS;
    end else if (ms_tick && boff_q != 12'h000) begin
      boff_d = boff_q - 12'h001;
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_q <= '0;
      div_q <= '0;
      faulted_q <= 1'b0;
      unplug_q <= '0;
      boff_q <= '0;
      oc_pulse_q <= 1'b0;
      unplug_pulse_q <= 1'b0;
      mon_q <= 1'b0;
    end else begin
      oc_q <= oc_d;
      div_q <= div_d;
      faulted_q <= faulted_d;
      unplug_q <= unplug_d;
      boff_q <= boff_d;
      oc_pulse_q <= oc_pulse_d;
      unplug_pulse_q <= unplug_pulse_d;
      mon_q <= mon_d;
    end
  end

  assign oc_shutdown = oc_pulse_q;
  assign unplug_shutdown = unplug_pulse_q;
  assign restart_hold = faulted_q && restart_en;
  assign backoff_hold = (boff_q != 12'h000);
  assign monitor_active = mon_q;

  // Fault shutdown only follows a powered port in current limit
  a_oc_cause: assert property (@(posedge clk) disable iff (!rst_n)
    oc_shutdown |-> $past(powered) && $past(in_limit) && $past(ms_tick))
    else $error("overcurrent shutdown without limit condition");
  // Unplug only while monitoring and without signature
  a_unplug_cause: assert property (@(posedge clk) disable iff (!rst_n)
    unplug_shutdown |-> $past(mon_q) && !$past(mps_seen))
    else $error("unplug shutdown without monitoring");
  // Failed detection with backoff on holds the port off; only a soft reset cuts it short
  a_backoff_load: assert property (@(posedge clk) disable iff (!rst_n)
    detect_fail && backoff_en && !soft_reset |=> backoff_hold ##1 (backoff_hold || $past(soft_reset)))
    else $error("backoff wait not started");

endmodule
`default_nettype wire

// File: rtl/poe_port_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module poe_port_config_regs
  import poe_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic addr_strap_bit3,
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit0,
  input wire logic midspan_strap,
  input wire logic autonomous_strap,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic restart_protection_enable,
  input wire logic [3:0] port_soft_reset,
  input wire logic [3:0] sw_power_off,
  input wire logic [3:0] powered,
  input wire logic [3:0] in_startup,
  input wire logic [3:0] power_good_flag,
  input wire logic [3:0] in_limit,
  input wire logic [3:0] mps_seen,
  input wire logic [3:0] det_done,
  input wire logic [3:0] cls_done,
  input wire logic [3:0] detect_fail,
  output logic [7:0] port_mode_field,
  output logic [3:0] det_start,
  output logic [3:0] cls_start,
  output logic [3:0] dc_unplug_monitor_enable,
  output logic [3:0] ac_unplug_monitor_enable,
  output logic [3:0] oc_shutdown,
  output logic [3:0] unplug_shutdown,
  output logic [3:0] restart_hold,
  output logic [3:0] backoff_hold
);

  // Reset release synchroniser and one-cycle strap-load pulse
  logic rst_s1_q, rst_n, seen_q;
  logic init_q, init_d;
  strap_t strap;
  // Configuration registers
  logic [7:0] mode_q, mode_d, unplug_q, unplug_d, disc_q, disc_d, timers_q, timers_d;
  logic [3:0] cadence_retry_enable_q, cadence_retry_enable_d;
  logic [7:0] rdata_q, rdata_d;
  // Millisecond divider
  logic [16:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  // Registered outputs toward the port engines
  logic [3:0] det_q, det_d, cls_q, cls_d, monitor_active;
  logic wr_mode;

  // Async assert, synchronous release of the reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Straps latch while reset is held, then freeze
  poe_strap_capture u_strap (
    .clk(core_clk),
    .rst_n(rst_n),
    .pins({addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, midspan_strap, autonomous_strap}),
    .strap(strap)
  );

  // Pulse once after release so strap-based defaults load from the latch
  assign init_d = !seen_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
      init_q <= init_d;
    end
  end

  assign wr_mode = reg_wr_en && (reg_addr == OFS_MODE);

  // Register bank next values: defaults, hardware clears, then software writes
  always_comb begin
    mode_d = mode_q;
    unplug_d = unplug_q;
    disc_d = disc_q;
    timers_d = timers_q;
    cadence_retry_enable_d = cadence_retry_enable_q;
    if (init_q) begin
      mode_d = {8{strap.autonomous}};
      unplug_d = {UPPER_NIBBLE_RESET, {4{strap.autonomous}}};
      disc_d = {8{strap.autonomous}};
      cadence_retry_enable_d = {4{strap.midspan & strap.autonomous}};
      timers_d = TIMERS_RESET;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        // Manual mode: routine completion clears its pushbutton
        if (port_mode_t'(mode_q[2*p +: 2]) == MODE_MANUAL) begin
          if (det_done[p]) begin
            disc_d[DET_LSB+p] = 1'b0;
          end
          if (cls_done[p]) begin
            disc_d[CLS_LSB+p] = 1'b0;
          end
        end
        // Semi mode: each commanded power-off clears the enables
        if (port_mode_t'(mode_q[2*p +: 2]) == MODE_SEMI && sw_power_off[p]) begin
          disc_d[DET_LSB+p] = 1'b0;
          disc_d[CLS_LSB+p] = 1'b0;
        end
      end
      // A write lands after the clears, so a set in the same cycle wins
      if (reg_wr_en) begin
        unique case (reg_addr)
          OFS_MODE: begin
            mode_d = reg_wdata;
            for (int p = 0; p < NUM_PORTS; p++) begin
              if (reg_wdata[2*p +: 2] != mode_q[2*p +: 2]) begin
                unique case (port_mode_t'(reg_wdata[2*p +: 2]))
                  MODE_AUTO: begin
                    disc_d[DET_LSB+p] = 1'b1;
                    disc_d[CLS_LSB+p] = 1'b1;
                  end
                  MODE_MANUAL: begin
                    disc_d[DET_LSB+p] = 1'b0;
                    disc_d[CLS_LSB+p] = 1'b0;
                  end
                  MODE_SEMI: ;
                  MODE_SHUTDOWN: ;
                endcase
              end
            end
          end
          OFS_UNPLUG: unplug_d = reg_wdata;
          OFS_DISCOVERY: disc_d = reg_wdata;
          OFS_BACKOFF: cadence_retry_enable_d = reg_wdata[3:0];
          OFS_TIMERS: timers_d = reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Register bank storage; port soft resets never reach it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '0;
      unplug_q <= '0;
      disc_q <= '0;
      timers_q <= TIMERS_RESET;
      cadence_retry_enable_q <= '0;
    end else begin
      mode_q <= mode_d;
      unplug_q <= unplug_d;
      disc_q <= disc_d;
      timers_q <= timers_d;
      cadence_retry_enable_q <= cadence_retry_enable_d;
    end
  end

  // Read data, registered; unmapped offsets and reserved bits read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_en) begin
      unique case (reg_addr)
        OFS_STRAP: rdata_d = {2'b00, strap};
        OFS_MODE: rdata_d = mode_q;
        OFS_UNPLUG: rdata_d = unplug_q;
        OFS_DISCOVERY: rdata_d = disc_q;
        OFS_BACKOFF: rdata_d = {UPPER_NIBBLE_RESET, cadence_retry_enable_q};
        OFS_TIMERS: rdata_d = timers_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Millisecond enable pulse for all port timers
  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 17'h00001;
    if (tick_cnt_q >= 17'(TICK_CYCLES - 1)) begin
      tick_cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  // Routine requests: detection has priority, classification alone if asked
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      det_d[p] = disc_q[DET_LSB+p] && (mode_q[2*p +: 2] != MODE_SHUTDOWN) && !backoff_hold[p];
      cls_d[p] = disc_q[CLS_LSB+p] && !disc_q[DET_LSB+p] && (mode_q[2*p +: 2] != MODE_SHUTDOWN);
    end
  end

  // Read data, divider and request registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
      det_q <= '0;
      cls_q <= '0;
    end else begin
      rdata_q <= rdata_d;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      det_q <= det_d;
      cls_q <= cls_d;
    end
  end

  // One timer engine per port, sharing the timing selects
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    poe_port_timer u_timer (
      .clk(core_clk),
      .rst_n(rst_n),
      .ms_tick(tick_q),
      .sel(timer_sel_t'(timers_q)),
      .restart_en(restart_protection_enable),
      .soft_reset(port_soft_reset[g]),
      .powered(powered[g]),
      .in_startup(in_startup[g]),
      .power_good(power_good_flag[g]),
      .in_limit(in_limit[g]),
      .mps_seen(mps_seen[g]),
      .monitor_en(unplug_q[DC_LSB+g] | unplug_q[AC_LSB+g]),
      .detect_fail(detect_fail[g]),
      .backoff_en(cadence_retry_enable_q[g]),
      .oc_shutdown(oc_shutdown[g]),
      .unplug_shutdown(unplug_shutdown[g]),
      .restart_hold(restart_hold[g]),
      .backoff_hold(backoff_hold[g]),
      .monitor_active(monitor_active[g])
    );
  end

  assign reg_rdata = rdata_q;
  assign port_mode_field = mode_q;
  assign det_start = det_q;
  assign cls_start = cls_q;
  // Monitor enables reach the analog side only once monitoring is armed
  assign dc_unplug_monitor_enable = unplug_q[DC_LSB +: 4] & monitor_active;
  assign ac_unplug_monitor_enable = unplug_q[AC_LSB +: 4] & monitor_active;

  // Strap-derived defaults appear right after the load pulse
  sequence s_init_load;
    init_q ##1 !init_q;
  endsequence

  a_strap_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> $stable(strap))
    else $error("strap latch changed outside reset");
  a_mode_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_init_load |-> mode_q == {8{strap.autonomous}})
    else $error("mode register default wrong");
  a_unplug_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_init_load |-> unplug_q == {4'h0, {4{strap.autonomous}}})
    else $error("disconnect enable default wrong");
  a_disc_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_init_load |-> disc_q == {8{strap.autonomous}})
    else $error("discovery enable default wrong");
  a_backoff_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_init_load |-> cadence_retry_enable_q == {4{strap.midspan & strap.autonomous}})
    else $error("backoff default wrong");
  // Entry into automatic mode: new mode and both enables show on the next cycle
  a_auto_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    !init_q && wr_mode && reg_wdata[1:0] == 2'b11 && mode_q[1:0] != 2'b11
    |=> disc_q[DET_LSB] && disc_q[CLS_LSB] && mode_q[1:0] == 2'b11)
    else $error("auto entry did not set enables");
  a_manual_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    !init_q && mode_q[1:0] == 2'b01 && det_done[0] && !reg_wr_en |=> !disc_q[DET_LSB])
    else $error("manual detection pushbutton not cleared");
  a_class_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    cls_start[0] |-> !$past(disc_q[DET_LSB]) && $past(disc_q[CLS_LSB]))
    else $error("classification requested while detection enabled");
  a_timer_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd_en && reg_addr == OFS_TIMERS |=> reg_rdata == $past(timers_q))
    else $error("timing register readback wrong");

endmodule
`default_nettype wire

// File: bench/poe_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host software side of the register port; one access per call
module poe_host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Write held over one rising edge; data inverted after so stale data never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask
  // Read data is registered, so it is taken half a cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: bench/test_poe_port_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_poe_port_config_regs;
  import poe_cfg_pkg::*;
  logic core_clk = 1'b0; // 100 MHz
  logic rst_b = 1'b0;
  logic [5:0] pins; // Straps as read back: addr, midspan, autonomous
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mode_out, rdv;
  logic reg_wr_en, reg_rd_en, rsten;
  logic [3:0] srst, poff, pwr, strt, pg, lim, mps, ddone, cdone, dfail, dst, cst, dcm, acm, oc, us, rh, bh;
  logic [7:0] m [8'h11:8'h16]; // Reference register image
  int error_cnt = 0;
  int samples_checked = 0;
  int n = 0; // Cycles counted in a timed wait
  // Short tick keeps timer paths inside a brief run
  localparam int TICK = 4;
  poe_port_config_regs #(.TICK_CYCLES(TICK)) i_poe_port_config_regs (.core_clk(core_clk), .rst_b(rst_b),
    .addr_strap_bit3(pins[5]), .addr_strap_bit2(pins[4]), .addr_strap_bit1(pins[3]), .addr_strap_bit0(pins[2]),
    .midspan_strap(pins[1]), .autonomous_strap(pins[0]), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .restart_protection_enable(rsten),
    .port_soft_reset(srst), .sw_power_off(poff), .powered(pwr), .in_startup(strt), .power_good_flag(pg),
    .in_limit(lim), .mps_seen(mps), .det_done(ddone), .cls_done(cdone), .detect_fail(dfail),
    .port_mode_field(mode_out), .det_start(dst), .cls_start(cst), .dc_unplug_monitor_enable(dcm),
    .ac_unplug_monitor_enable(acm), .oc_shutdown(oc), .unplug_shutdown(us), .restart_hold(rh), .backoff_hold(bh));
  poe_host_model i_poe_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));
  always #5 core_clk = ~core_clk;
  // Compare one result and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reference write, including mode entry side effects on the discovery enables
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_poe_host_model.wr(a, d);
    if (a == OFS_MODE) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (d[2*p+:2] != m[a][2*p+:2] && d[2*p+:2] == MODE_AUTO) {m[OFS_DISCOVERY][p+4], m[OFS_DISCOVERY][p]} = 2'b11;
        if (d[2*p+:2] != m[a][2*p+:2] && d[2*p+:2] == MODE_MANUAL) {m[OFS_DISCOVERY][p+4], m[OFS_DISCOVERY][p]} = 2'b00;
      end
    end
    if (a == OFS_BACKOFF) m[a] = {4'h0, d[3:0]};
    else if (a > OFS_STRAP && a <= OFS_TIMERS) m[a] = d;
  endtask
  // Read back and compare with the image; unmapped reads give zero
  task automatic rchk(input logic [7:0] a);
    i_poe_host_model.rd(a, rdv);
    chk(rdv, (a >= OFS_STRAP && a <= OFS_TIMERS) ? m[a] : 8'h00);
  endtask
  // Hardware reset with fresh random straps, then the strap defaults in the image
  task automatic do_reset();
    pins = 6'($urandom);
    rst_b = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    m[OFS_STRAP] = {2'b00, pins};
    m[OFS_MODE] = {8{pins[0]}};
    m[OFS_UNPLUG] = {4'h0, {4{pins[0]}}};
    m[OFS_DISCOVERY] = {8{pins[0]}};
    m[OFS_BACKOFF] = {4'h0, {4{pins[1] & pins[0]}}};
    m[OFS_TIMERS] = TIMERS_RESET;
    repeat (5) @(negedge core_clk);
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the roughly ten thousand cycles the tests need
  initial begin
    #300000;
    error_cnt++;
    final_report();
  end
  initial begin
    {srst, poff, pwr, strt, pg, lim, mps, ddone, cdone, dfail} = '0;
    rsten = 1'b0;
    pins = '0;
    void'($urandom(59283));
    // Defaults follow the straps; later strap changes are ignored
    for (int k = 0; k < 4; k++) begin
      do_reset();
      for (int a = 8'h10; a <= 8'h17; a++) rchk(8'(a));
      pins = ~pins;
      rchk(OFS_STRAP);
      $display("test reset_defaults %0d done", k);
    end
    // Random writes everywhere, including read-only and unmapped places
    for (int k = 0; k < 8; k++) begin
      for (int a = 8'h11; a <= 8'h17; a++) wr(8'(a), 8'($urandom));
      for (int a = 8'h11; a <= 8'h17; a++) rchk(8'(a));
      chk(mode_out, m[OFS_MODE]);
    end
    $display("test random_access done");
    // Semi mode keeps enables until a power-off; soft reset leaves modes alone
    wr(OFS_MODE, 8'h00);
    wr(OFS_MODE, 8'haa);
    wr(OFS_DISCOVERY, 8'h5a);
    rchk(OFS_DISCOVERY);
    poff = 4'b0101;
    @(negedge core_clk);
    poff = 4'b0000;
    m[OFS_DISCOVERY] = m[OFS_DISCOVERY] & 8'haa;
    srst = 4'hf;
    @(negedge core_clk);
    srst = 4'h0;
    rchk(OFS_DISCOVERY);
    rchk(OFS_MODE);
    wr(OFS_MODE, 8'hff);
    rchk(OFS_DISCOVERY);
    $display("test mode_entry done");
    // Manual pushbuttons: detection before classification, cleared on completion
    wr(OFS_MODE, 8'h55);
    rchk(OFS_DISCOVERY);
    wr(OFS_BACKOFF, 8'h00);
    wr(OFS_DISCOVERY, 8'h31);
    repeat (2) @(negedge core_clk);
    chk({4'h0, dst}, 8'h01);
    chk({4'h0, cst}, 8'h02);
    ddone = 4'b0001;
    cdone = 4'b0010;
    @(negedge core_clk);
    {ddone, cdone} = '0;
    m[OFS_DISCOVERY] = 8'h10;
    rchk(OFS_DISCOVERY);
    $display("test manual_buttons done");
    // Disconnect monitoring armed only after startup with power good
    rdv = 8'($urandom);
    wr(OFS_UNPLUG, rdv);
    {pwr, pg, strt} = {4'hf, 4'hf, 4'h0};
    repeat (3) @(negedge core_clk);
    chk({acm, dcm}, rdv);
    strt = 4'hf;
    repeat (3) @(negedge core_clk);
    chk({acm, dcm}, 8'h00);
    $display("test unplug_arming done");
    // Current-limit timeouts while running and in startup, then the restart hold
    {strt, mps} = {4'h0, 4'hf};
    for (int ph = 0; ph < 2; ph++) begin
      wr(OFS_TIMERS, 8'h25);
      strt = 4'(ph);
      rsten = 1'b1;
      lim = 4'h1;
      n = 0;
      while (!oc[0] && n < 1000) begin
        @(negedge core_clk);
        n++;
      end
      chk(8'((n - 1) / TICK), ph ? 8'(TSTART_NOM_MS * 2 - 1) : 8'(TFAULT_NOM_MS / 2 - 1));
      @(negedge core_clk);
      chk({6'h0, oc[0], rh[0]}, 8'h01);
      rsten = 1'b0;
      @(negedge core_clk);
      chk({7'h0, rh[0]}, 8'h00);
      lim = 4'h0;
      wr(OFS_TIMERS, 8'he5);
      rsten = 1'b1;
      @(negedge core_clk);
      chk({7'h0, rh[0]}, 8'h00);
    end
    // Missing signature for longer than a quarter of the nominal disconnect time
    strt = 4'h0;
    wr(OFS_UNPLUG, 8'h01);
    @(negedge core_clk);
    mps = 4'he;
    n = 0;
    while (!us[0] && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'((n - 1) / TICK), 8'(UNPLUG_TIMEOUT_SELECT_NOM_MS / 4));
    mps = 4'hf;
    // Cadence wait after a failed detection, then one cut short by a port soft reset
    wr(OFS_BACKOFF, 8'h01);
    dfail = 4'h1;
    @(negedge core_clk);
    dfail = 4'h0;
    n = 0;
    while (bh[0] && n < 10000) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'((n + 3) / 400), 8'(BACKOFF_MS * TICK / 400));
    dfail = 4'h1;
    @(negedge core_clk);
    dfail = 4'h0;
    @(negedge core_clk);
    chk({4'h0, bh}, 8'h01);
    srst = 4'h1;
    @(negedge core_clk);
    srst = 4'h0;
    chk({4'h0, bh}, 8'h00);
    $display("test port_timers done");
    final_report();
  end
endmodule
`default_nettype wire
